/* hdl/rtb_core.sv */
// Coarse trim, supply switchover and power-fail timestamp logic of the clock
`timescale 1ns/1ps
module rtb_core
  import rtb_pkg::*;
#(
  parameter int MINUTE_TICKS = RTB_MINUTE_TICKS
) (
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire rtb_reg_req_t REG_REQ_I,
  output logic [7:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  output logic REG_NACK_O,
  input wire logic OSC_TICK_I,
  input wire rtb_stamp_t TIME_NOW_I,
  input wire logic VCC_BELOW_TRIP_I,
  output logic BACKUP_ACTIVE_O,
  output logic TRIM_PULSE_O,
  output logic TRIM_SIGN_O,
  output logic [7:0] TRIM_CLOCKS_O,
  output logic SQW_PATH_EN_O,
  output logic [1:0] SQW_FREQ_SEL_O,
  output logic [1:0] ALARM_EN_O,
  output logic EXT_CLK_SEL_O,
  output logic MULTI_FUNCTION_PIN_O,
  output logic MULTI_FUNCTION_PIN_OE_O
);

  typedef struct packed {
    logic [1:0] vcc_sync;
    logic backup;
    logic [7:0] control;
    logic [7:0] trim;
    logic vbat_en;
    logic pwr_fail;
    logic up_pending;
    logic [RTB_TICK_W-1:0] tick_cnt;
    logic sqw;
    logic trim_pulse;
    logic rd_stage;
    logic rd_from_mem;
    logic [7:0] rd_local;
    logic [7:0] rdata;
    logic rvalid;
    logic nack;
    logic sqw_path;
    logic pin_oe;
  } rtb_core_st_t;

  rtb_core_st_t st_ff;
  rtb_core_st_t nxt_st;

  logic [7:0] mem_rd_data;
  logic cap_en;
  logic cap_set;
  logic stamp_clr;
  logic mem_wr;
  rtb_stamp_t cap_data;
  logic [RTB_TICK_W-1:0] tick_limit;
  logic trim_event;
  logic access_ok;
  logic in_stamp_page;
  logic [7:0] stamp_mask;
  logic power_loss;

  // ==========================================================
  // Decode helpers
  // Trim interval is counted in oscillator ticks so the rate is exact at any fabric clock
  always_comb begin
    tick_limit = st_ff.control[RTB_CTL_COARSE_TRIM_ENABLE]
               ? RTB_TICK_W'(RTB_COARSE_TICKS - 1)
               : RTB_TICK_W'(MINUTE_TICKS - 1);
    trim_event = OSC_TICK_I && (st_ff.tick_cnt >= tick_limit);
    access_ok = !st_ff.backup;
    in_stamp_page = (REG_REQ_I.addr[7:3] == RTB_STAMP_PAGE);
    unique case (REG_REQ_I.addr[1:0])
      2'b00: stamp_mask = RTB_MASK_MIN;
      2'b01: stamp_mask = RTB_MASK_HOUR;
      2'b10: stamp_mask = RTB_MASK_DATE;
      2'b11: stamp_mask = RTB_MASK_MTH;
    endcase
  end

  // Snapshot of the live counters with unimplemented bits forced low
  always_comb begin
    cap_data.min = TIME_NOW_I.min & RTB_MASK_MIN;
    cap_data.hour = TIME_NOW_I.hour & RTB_MASK_HOUR;
    cap_data.date = TIME_NOW_I.date & RTB_MASK_DATE;
    cap_data.mth = TIME_NOW_I.mth & RTB_MASK_MTH;
  end

  // ==========================================================
  // Next state
  always_comb begin
    nxt_st = st_ff;
    cap_en = 1'b0;
    cap_set = 1'b0;
    stamp_clr = 1'b0;
    mem_wr = 1'b0;

    // Comparator level crosses domains through two flops
    nxt_st.vcc_sync = {st_ff.vcc_sync[0], VCC_BELOW_TRIP_I};
    // Backup only taken when its input is enabled
    nxt_st.backup = st_ff.vcc_sync[1] && st_ff.vbat_en;
    power_loss = !st_ff.backup && nxt_st.backup;

    // Power loss: log the down stamp only if the power fail flag is still clear
    if (power_loss) begin
      nxt_st.pwr_fail = 1'b1;
      if (!st_ff.pwr_fail) begin
        cap_en = 1'b1;
        cap_set = 1'b0;
        nxt_st.up_pending = 1'b1;
      end
    end
    // Power return: the up stamp pairs with the down stamp just taken
    if (st_ff.backup && !nxt_st.backup && st_ff.up_pending) begin
      cap_en = 1'b1;
      cap_set = 1'b1;
      nxt_st.up_pending = 1'b0;
    end

    // Trim interval keeps running on backup since timekeeping does
    nxt_st.trim_pulse = 1'b0;
    if (OSC_TICK_I) begin
      nxt_st.tick_cnt = trim_event ? '0 : st_ff.tick_cnt + 1'b1;
    end
    if (trim_event) begin
      nxt_st.trim_pulse = (st_ff.trim[6:0] != 7'h00);
      if (st_ff.control[RTB_CTL_COARSE_TRIM_ENABLE]) begin
        nxt_st.sqw = !st_ff.sqw;
      end
    end

    // Register access, refused outright while on backup
    nxt_st.rvalid = st_ff.rd_stage;
    nxt_st.rdata = st_ff.rd_from_mem ? mem_rd_data : st_ff.rd_local;
    nxt_st.rd_stage = 1'b0;
    nxt_st.nack = (REG_REQ_I.rd || REG_REQ_I.wr) && !access_ok;
    if (REG_REQ_I.wr && access_ok) begin
      if (REG_REQ_I.addr == RTB_ADDR_CONTROL) begin
        nxt_st.control = REG_REQ_I.wdata;
        // A mode change restarts the interval so a long count never overshoots
        if (REG_REQ_I.wdata[RTB_CTL_COARSE_TRIM_ENABLE]
            != st_ff.control[RTB_CTL_COARSE_TRIM_ENABLE]) begin
          nxt_st.tick_cnt = '0;
        end
      end
      if (REG_REQ_I.addr == RTB_ADDR_TRIM) begin
        nxt_st.trim = REG_REQ_I.wdata;
      end
      if (REG_REQ_I.addr == RTB_ADDR_SUPPLY) begin
        nxt_st.vbat_en = REG_REQ_I.wdata[RTB_SUP_BACKUP_INPUT_ENABLE];
        // Writing zero clears the flag; a power loss in the same cycle wins
        if (!REG_REQ_I.wdata[RTB_SUP_POWER_FAIL_FLAG] && st_ff.pwr_fail && !power_loss) begin
          nxt_st.pwr_fail = 1'b0;
          nxt_st.up_pending = 1'b0;
          stamp_clr = 1'b1;
        end
      end
      mem_wr = in_stamp_page;
    end
    if (REG_REQ_I.rd && access_ok) begin
      nxt_st.rd_stage = 1'b1;
      nxt_st.rd_from_mem = in_stamp_page;
      unique case (REG_REQ_I.addr)
        RTB_ADDR_CONTROL: nxt_st.rd_local = st_ff.control;
        RTB_ADDR_TRIM: nxt_st.rd_local = st_ff.trim;
        RTB_ADDR_SUPPLY: nxt_st.rd_local = 8'({st_ff.pwr_fail, st_ff.vbat_en, 3'b000});
        default: nxt_st.rd_local = 8'h00;
      endcase
    end

    // Output pin gating: square wave and general output die on backup
    nxt_st.sqw_path = nxt_st.control[RTB_CTL_SQUARE_WAVE_ENABLE]
                    && !nxt_st.control[RTB_CTL_COARSE_TRIM_ENABLE]
                    && !nxt_st.backup;
    nxt_st.pin_oe = 1'b0;
    if (!nxt_st.backup) begin
      if (nxt_st.control[RTB_CTL_SQUARE_WAVE_ENABLE]
          && nxt_st.control[RTB_CTL_COARSE_TRIM_ENABLE]) begin
        nxt_st.pin_oe = !nxt_st.sqw;
      end else if (!nxt_st.control[RTB_CTL_SQUARE_WAVE_ENABLE]
                   && !nxt_st.control[RTB_CTL_FIRST_ALARM_ENABLE]
                   && !nxt_st.control[RTB_CTL_SECOND_ALARM_ENABLE]) begin
        nxt_st.pin_oe = !nxt_st.control[RTB_CTL_OUT];
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      st_ff <= '0;
      st_ff.control <= RTB_CONTROL_RST;
      st_ff.trim <= RTB_TRIM_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Timestamp store; masks applied on software writes as well
  rtb_stamp_mem u_stamp_mem (
    .clk_i(CLK_I),
    .rst_b_i(RST_B_I),
    .wr_i(mem_wr),
    .wr_addr_i(REG_REQ_I.addr[2:0]),
    .wr_data_i(REG_REQ_I.wdata & stamp_mask),
    .cap_i(cap_en),
    .cap_set_i(cap_set),
    .cap_data_i(cap_data),
    .clr_i(stamp_clr),
    .rd_addr_i(REG_REQ_I.addr[2:0]),
    .rd_data_o(mem_rd_data)
  );

  // ==========================================================
  // Outputs, each straight from a flop
  assign REG_RDATA_O = st_ff.rdata;
  assign REG_RVALID_O = st_ff.rvalid;
  assign REG_NACK_O = st_ff.nack;
  assign BACKUP_ACTIVE_O = st_ff.backup;
  assign TRIM_PULSE_O = st_ff.trim_pulse;
  assign TRIM_SIGN_O = st_ff.trim[RTB_TRIM_SIGN];
  assign TRIM_CLOCKS_O = {st_ff.trim[6:0], 1'b0};
  assign SQW_PATH_EN_O = st_ff.sqw_path;
  assign SQW_FREQ_SEL_O = st_ff.control[1:0];
  assign ALARM_EN_O = {st_ff.control[RTB_CTL_SECOND_ALARM_ENABLE],
                       st_ff.control[RTB_CTL_FIRST_ALARM_ENABLE]};
  assign EXT_CLK_SEL_O = st_ff.control[RTB_CTL_EXTERNAL_CLOCK_SELECT];
  assign MULTI_FUNCTION_PIN_O = st_ff.pin_oe & 1'b0;  // Open drain: only ever pulls low
  assign MULTI_FUNCTION_PIN_OE_O = st_ff.pin_oe;

  // ==========================================================
  // Checks
  sequence seq_power_loss;
    !st_ff.backup ##1 st_ff.backup;
  endsequence

  sequence seq_bus_attempt;
    st_ff.backup && (REG_REQ_I.rd || REG_REQ_I.wr);
  endsequence

  a_fail_flag_set: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    seq_power_loss |-> st_ff.pwr_fail)
    else $error("power fail flag not set on switchover");

  a_bus_refused: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    seq_bus_attempt |=> (REG_NACK_O && !REG_RVALID_O))
    else $error("bus access not refused on backup");

  a_pin_quiet_backup: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    st_ff.backup |-> (!MULTI_FUNCTION_PIN_OE_O && !SQW_PATH_EN_O))
    else $error("output pin active on backup");

  a_no_overwrite: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (st_ff.pwr_fail && !st_ff.backup) |-> !(cap_en && !cap_set))
    else $error("down stamp overwritten while flag set");

  a_enable_gates_switch: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    !st_ff.vbat_en |=> !st_ff.backup)
    else $error("backup taken with input disabled");

  a_switch_follows: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (VCC_BELOW_TRIP_I && st_ff.vbat_en)[*3] |=> st_ff.backup)
    else $error("no switchover after supply fall");

  a_coarse_interval: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    TRIM_PULSE_O |-> ($past(st_ff.tick_cnt) == $past(tick_limit)))
    else $error("trim pulse off its interval");

  a_coarse_toggle: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (trim_event && st_ff.control[RTB_CTL_COARSE_TRIM_ENABLE])
    |=> (st_ff.sqw != $past(st_ff.sqw)))
    else $error("square wave did not toggle");

  a_read_latency: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (REG_REQ_I.rd && !st_ff.backup) |-> ##2 REG_RVALID_O)
    else $error("read answer not on second edge");

  // Supply return and flag clear, the two events that retire a logged pair
  sequence seq_power_return;
    st_ff.backup ##1 !st_ff.backup;
  endsequence

  sequence seq_flag_clear;
    REG_REQ_I.wr && (REG_REQ_I.addr == RTB_ADDR_SUPPLY) && !st_ff.backup
    && !REG_REQ_I.wdata[RTB_SUP_POWER_FAIL_FLAG] && !power_loss;
  endsequence

  a_up_stamp_spent: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    seq_power_return |-> !st_ff.up_pending)
    else $error("up stamp still pending after return");

  a_flag_clear: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    seq_flag_clear |=> (!st_ff.pwr_fail && !st_ff.up_pending))
    else $error("power fail flag not cleared by write");

  a_trim_zero_quiet: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (trim_event && (st_ff.trim[6:0] == 7'h00)) |=> !TRIM_PULSE_O)
    else $error("trim pulse with zero magnitude");

  a_coarse_pin: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (!st_ff.backup && st_ff.control[RTB_CTL_SQUARE_WAVE_ENABLE]
     && st_ff.control[RTB_CTL_COARSE_TRIM_ENABLE])
    |-> (MULTI_FUNCTION_PIN_OE_O == !st_ff.sqw))
    else $error("coarse square wave not on pin");

  // General output owns the pin only when no clock or alarm claims it
  a_general_output: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (!st_ff.backup && !st_ff.control[RTB_CTL_SQUARE_WAVE_ENABLE]
     && !st_ff.control[RTB_CTL_FIRST_ALARM_ENABLE]
     && !st_ff.control[RTB_CTL_SECOND_ALARM_ENABLE])
    |-> (MULTI_FUNCTION_PIN_OE_O == !st_ff.control[RTB_CTL_OUT]))
    else $error("general output not on pin");

  a_switch_synced: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    $rose(st_ff.backup) |-> ($past(st_ff.vcc_sync[1]) && $past(st_ff.vbat_en)))
    else $error("switchover without synced comparator");

  a_read_no_refusal: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (REG_REQ_I.rd && !st_ff.backup) |=> !REG_NACK_O)
    else $error("read refused on main supply");

endmodule // rtb_core

/* hdl/rtb_pkg.sv */
// Package of constants and carrier types for the trim, backup and timestamp block
package rtb_pkg;

  // ==========================================================
  // Register byte addresses
  localparam logic [7:0] RTB_ADDR_SUPPLY = 8'h03;
  localparam logic [7:0] RTB_ADDR_CONTROL = 8'h07;
  localparam logic [7:0] RTB_ADDR_TRIM = 8'h08;
  localparam logic [7:0] RTB_ADDR_DN_MIN = 8'h18;
  localparam logic [7:0] RTB_ADDR_DN_HOUR = 8'h19;
  localparam logic [7:0] RTB_ADDR_UP_MIN = 8'h1C;
  localparam logic [7:0] RTB_ADDR_UP_HOUR = 8'h1D;
  // Upper five address bits shared by all eight stamp bytes
  localparam logic [4:0] RTB_STAMP_PAGE = 5'h03;

  // ==========================================================
  // Field positions
  localparam int RTB_CTL_OUT = 7;
  localparam int RTB_CTL_SQUARE_WAVE_ENABLE = 6;
  localparam int RTB_CTL_SECOND_ALARM_ENABLE = 5;
  localparam int RTB_CTL_FIRST_ALARM_ENABLE = 4;
  localparam int RTB_CTL_EXTERNAL_CLOCK_SELECT = 3;
  localparam int RTB_CTL_COARSE_TRIM_ENABLE = 2;
  localparam int RTB_TRIM_SIGN = 7;
  localparam int RTB_SUP_POWER_FAIL_FLAG = 4;
  localparam int RTB_SUP_BACKUP_INPUT_ENABLE = 3;

  // ==========================================================
  // Reset values and implemented-bit masks of the stamp bytes
  localparam logic [7:0] RTB_CONTROL_RST = 8'h80;
  localparam logic [7:0] RTB_TRIM_RST = 8'h00;
  localparam logic [7:0] RTB_STAMP_RST = 8'h00;
  localparam logic [7:0] RTB_MASK_MIN = 8'h7F;
  localparam logic [7:0] RTB_MASK_HOUR = 8'h7F;
  localparam logic [7:0] RTB_MASK_DATE = 8'h3F;
  localparam logic [7:0] RTB_MASK_MTH = 8'hFF;

  // ==========================================================
  // Oscillator tick counts
  localparam int RTB_TICK_W = 21;
  localparam int RTB_COARSE_TICKS = 256;       // 32768 / 128
  localparam int RTB_MINUTE_TICKS = 1966080;   // 32768 * 60

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtb_reg_req_t;

  typedef struct packed {
    logic [7:0] mth;
    logic [7:0] date;
    logic [7:0] hour;
    logic [7:0] min;
  } rtb_stamp_t;

endpackage : rtb_pkg

/* hdl/rtb_stamp_mem.sv */
// Eight-byte timestamp store with capture, clear-all and registered read
`timescale 1ns/1ps
module rtb_stamp_mem
  import rtb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic wr_i,
  input wire logic [2:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic cap_i,
  input wire logic cap_set_i,
  input wire rtb_stamp_t cap_data_i,
  input wire logic clr_i,
  input wire logic [2:0] rd_addr_i,
  output logic [7:0] rd_data_o
);

  typedef struct packed {
    logic [7:0][7:0] mem;
    logic [7:0] rd_data;
  } rtb_mem_st_t;

  rtb_mem_st_t st_ff;
  rtb_mem_st_t nxt_st;

  // ==========================================================
  // Next state: capture wins over clear so a power event is never lost
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rd_data = st_ff.mem[rd_addr_i];
    if (clr_i) begin
      nxt_st.mem = '0;
    end
    if (wr_i) begin
      nxt_st.mem[wr_addr_i] = wr_data_i;
    end
    if (cap_i) begin
      nxt_st.mem[{cap_set_i, 2'b11}] = cap_data_i.mth;
      nxt_st.mem[{cap_set_i, 2'b10}] = cap_data_i.date;
      nxt_st.mem[{cap_set_i, 2'b01}] = cap_data_i.hour;
      nxt_st.mem[{cap_set_i, 2'b00}] = cap_data_i.min;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_data_o = st_ff.rd_data;

  // ==========================================================
  // Checks
  a_clear_wipes_all: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (clr_i && !cap_i && !wr_i) |=> (st_ff.mem == '0))
    else $error("stamp store not cleared");

  a_capture_lands: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cap_i |=> (st_ff.mem[{$past(cap_set_i), 2'b00}] == $past(cap_data_i.min)))
    else $error("captured minutes not stored");

endmodule // rtb_stamp_mem

/* verification/rtb_host_model.sv */
// Host-side model that issues byte register requests to the block
`timescale 1ns/1ps
module rtb_host_model
  import rtb_pkg::*;
(
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  input wire logic nack_i,
  output rtb_reg_req_t req_o
);
  // ==========================================================
  // Requests
  // Idle until a task raises a strobe
  initial req_o = '0;

  // One-cycle write strobe; released fields show inverted values, never stale ones
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_i);
    #1;
    req_o = '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
    @(posedge clk_i);
    #1;
    req_o = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~data};
  endtask

  // One-cycle read strobe, then a bounded wait for data or refusal
  task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic refused);
    data = 'x;
    refused = 1'b0;
    @(posedge clk_i);
    #1;
    req_o = '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 8'h00};
    @(posedge clk_i);
    #1;
    req_o = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: 8'hFF};
    for (int i = 0; i < 3; i++) begin
      if (nack_i === 1'b1) begin
        refused = 1'b1;
        break;
      end
      if (rvalid_i === 1'b1) begin
        data = rdata_i;
        break;
      end
      @(posedge clk_i);
      #1;
    end
  endtask
endmodule // rtb_host_model

/* verification/test_rtb_core.sv */
// Self-checking bench for the trim, backup and timestamp block
`timescale 1ns/1ps
module test_rtb_core
  import rtb_pkg::*;
();
  // ==========================================================
  // Signals
  localparam int MIN_TICKS = 600;
  localparam int TICK_DIV = 4;
  localparam int PPM = 6;
  localparam logic [6:0] TRIM_MAG = 7'((PPM * 32768 * 60) / (1000000 * 2));
  logic CLK_I = 1'b0;
  logic RST_B_I = 1'b0;
  rtb_reg_req_t reg_req;
  logic [7:0] reg_rdata, trim_clocks, rv;
  logic reg_rvalid, reg_nack, backup, trim_pulse, trim_sign, sqw_en, pin_oe, rf, pin_a, ext_clk;
  logic osc_tick = 1'b0;
  logic vcc_below = 1'b0;
  rtb_stamp_t time_now = '0;
  logic [1:0] sqw_sel, alarm_en;
  logic [1:0] tdiv = 2'h0;
  logic [7:0] masks [4] = '{RTB_MASK_MIN, RTB_MASK_HOUR, RTB_MASK_DATE, RTB_MASK_MTH};
  logic [7:0] stamps [8] = '{8'h59, 8'h72, 8'h31, 8'h25, 8'h05, 8'h23, 8'h07, 8'h46};
  int fail_count = 0;
  int checks = 0;
  int gap;

  // Clock and one oscillator tick every fourth cycle
  always #5 CLK_I = ~CLK_I;
  always @(posedge CLK_I) begin
    #1;
    tdiv = tdiv + 2'h1;
    osc_tick = (tdiv == 2'h0);
  end

  // ==========================================================
  // Instances
  rtb_core #(.MINUTE_TICKS(MIN_TICKS)) rtb_core_i (
    .CLK_I(CLK_I), .RST_B_I(RST_B_I), .REG_REQ_I(reg_req), .REG_RDATA_O(reg_rdata),
    .REG_RVALID_O(reg_rvalid), .REG_NACK_O(reg_nack), .OSC_TICK_I(osc_tick),
    .TIME_NOW_I(time_now), .VCC_BELOW_TRIP_I(vcc_below), .BACKUP_ACTIVE_O(backup),
    .TRIM_PULSE_O(trim_pulse), .TRIM_SIGN_O(trim_sign), .TRIM_CLOCKS_O(trim_clocks),
    .SQW_PATH_EN_O(sqw_en), .SQW_FREQ_SEL_O(sqw_sel), .ALARM_EN_O(alarm_en),
    .EXT_CLK_SEL_O(ext_clk), .MULTI_FUNCTION_PIN_O(), .MULTI_FUNCTION_PIN_OE_O(pin_oe));
  rtb_host_model rtb_host_model_i (
    .clk_i(CLK_I), .rdata_i(reg_rdata), .rvalid_i(reg_rvalid), .nack_i(reg_nack),
    .req_o(reg_req));

  // ==========================================================
  // Helpers
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    rtb_host_model_i.rd(addr, rv, rf);
    chk($sformatf("reg %h", addr), 32'(exp), 32'(rv));
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge CLK_I);
    #2;
  endtask
  // Cycles between two trim pulses, bounded so a silent design cannot hang
  task automatic trim_gap(output int g);
    g = 0;
    while (trim_pulse !== 1'b1 && g < 3000) begin step(1); g++; end
    g = 1;
    step(1);
    while (trim_pulse !== 1'b1 && g < 3000) begin step(1); g++; end
  endtask
  // Moves the supply comparator and counts cycles until the block follows
  task automatic supply(input logic below, output int n);
    @(posedge CLK_I);
    #1;
    vcc_below = below;
    n = 0;
    while (backup !== below && n < 10) begin step(1); n++; end
    chk("switch delay", 32'h1, 32'(n >= 2 && n <= 4));
  endtask
  task automatic stamp_chk(input logic zero);
    for (int i = 0; i < 8; i++) rd_chk(8'h18 + 8'(i), zero ? 8'h00 : stamps[i]);
  endtask
  task automatic test_done();
    if (fail_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial begin
    repeat (3) @(posedge CLK_I);
    #1;
    RST_B_I = 1'b1;
    stamp_chk(1'b1);
    rd_chk(RTB_ADDR_CONTROL, RTB_CONTROL_RST);
    rd_chk(8'h40, 8'h00);
    // Unimplemented stamp bits stay zero whatever is written
    for (int i = 0; i < 8; i++) begin
      rtb_host_model_i.wr(8'h18 + 8'(i), 8'hFF);
      rd_chk(8'h18 + 8'(i), masks[i % 4]);
    end
    // Comparator is ignored while the backup input is disabled
    vcc_below = 1'b1;
    step(8);
    chk("backup while disabled", 32'h0, 32'(backup));
    vcc_below = 1'b0;
    step(4);
    // Coarse trim: pulse every 256 ticks, square wave halves it
    rtb_host_model_i.wr(RTB_ADDR_TRIM, {1'b1, TRIM_MAG});
    rtb_host_model_i.wr(RTB_ADDR_CONTROL, 8'h74);
    step(1);
    chk("trim clocks", 32'({TRIM_MAG, 1'b0}), 32'(trim_clocks));
    chk("trim sign", 32'h1, 32'(trim_sign));
    trim_gap(gap);
    pin_a = pin_oe;
    trim_gap(gap);
    chk("coarse gap", 32'(256 * TICK_DIV), 32'(gap));
    chk("coarse square", 32'(!pin_a), 32'(pin_oe));
    // Normal trim once a minute and the plain square-wave path
    rtb_host_model_i.wr(RTB_ADDR_CONTROL, 8'h43);
    step(1);
    chk("square path", 32'h7, 32'({sqw_en, sqw_sel}));
    trim_gap(gap);
    trim_gap(gap);
    chk("minute gap", 32'(MIN_TICKS * TICK_DIV), 32'(gap));
    rtb_host_model_i.wr(RTB_ADDR_CONTROL, 8'h74);
    // Power loss captures the down stamp and gates the square-wave path and the pin, not the alarm enables
    rtb_host_model_i.wr(RTB_ADDR_SUPPLY, 8'h08);
    time_now = '{mth: 8'h25, date: 8'h31, hour: 8'h72, min: 8'h59};
    supply(1'b1, gap);
    chk("square on backup", 32'h0, 32'(sqw_en));
    trim_gap(gap);
    chk("backup gap", 32'(256 * TICK_DIV), 32'(gap));
    chk("coarse out on backup", 32'h0, 32'(pin_oe));
    chk("alarms on backup", 32'h3, 32'(alarm_en));
    rtb_host_model_i.rd(RTB_ADDR_CONTROL, rv, rf);
    chk("refused read", 32'h1, 32'(rf));
    time_now = '{mth: 8'h46, date: 8'h07, hour: 8'h23, min: 8'h05};
    supply(1'b0, gap);
    rd_chk(RTB_ADDR_SUPPLY, 8'h18);
    stamp_chk(1'b0);
    // A second loss with the flag still set keeps the old stamps
    time_now = '{mth: 8'h11, date: 8'h11, hour: 8'h11, min: 8'h11};
    supply(1'b1, gap);
    supply(1'b0, gap);
    stamp_chk(1'b0);
    // Clearing the flag wipes all eight stamp bytes
    rtb_host_model_i.wr(RTB_ADDR_SUPPLY, 8'h08);
    stamp_chk(1'b1);
    rd_chk(RTB_ADDR_SUPPLY, 8'h08);
    // General output pulls the pin when OUT is clear and nothing else claims it
    rtb_host_model_i.wr(RTB_ADDR_CONTROL, 8'h08);
    step(1);
    chk("general out", 32'h3, 32'({pin_oe, ext_clk}));
    test_done();
  end

  // Watchdog: the tests take about 12500 cycles
  initial begin
    #500_000;
    fail_count++;
    test_done();
  end
endmodule // test_rtb_core
